//--- rtl/iob_axil.sv
/*
 * AXI4-Lite slave front end: accepts one write and one read at a
 * time and hands the decoded access to the register file.
 * Assumes a single clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module iob_axil
    import iob_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok,
    input  wire logic        wr_ok
);

    typedef struct packed {
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        arready;
    } iob_axs_s;

    iob_axs_s st_reg;
    iob_axs_s st_next;
    logic     wr_fire;

    // write fires once both halves are held and no response is pending
    assign wr_fire       = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    assign wr_en         = wr_fire;
    assign wr_addr       = st_reg.awaddr;
    assign wr_data       = st_reg.wdata;
    assign wr_strb       = st_reg.wstrb;
    assign rd_addr       = s_axi_araddr;
    assign s_axi_awready = !st_reg.aw_have;
    assign s_axi_wready  = !st_reg.w_have;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

    always_comb
    begin
        st_next = st_reg;
        if (s_axi_awvalid && !st_reg.aw_have)
        begin
            st_next.aw_have = 1'b1;
            st_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_have)
        begin
            st_next.w_have = 1'b1;
            st_next.wdata  = s_axi_wdata;
            st_next.wstrb  = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        st_next.arready = !st_reg.rvalid && !st_reg.arready;
        if (s_axi_arvalid && st_reg.arready)
        begin
            st_next.arready = 1'b0;
            st_next.rvalid  = 1'b1;
            st_next.rdata   = rd_data;
            st_next.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (st_reg.arready)
            st_next.arready = 1'b1;
        if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

endmodule

//--- rtl/iob_device.sv
/*
 * In-out bus peripheral: device select, busy/done/interrupt-disable
 * flags, control functions, skip tests and A/B buffer transfers,
 * with an AXI4-Lite port for the peripheral's own logic.
 * Assumes the processor presents one instruction per strobe cycle
 * and the bus clear and mask-out as one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
module iob_device
    import iob_pkg::*;
#(
    parameter logic [5:0] DEV_CODE   = 6'h0A,
    parameter int         MASK_BIT   = 4,
    parameter int         A_WIDTH    = 8,
    parameter int         B_WIDTH    = 16,
    parameter bit         HAS_A      = 1'b1,
    parameter bit         HAS_B      = 1'b1
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire iob_cpu_s    cpu_in,
    output iob_dev_s         dev_out,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  busy;
        logic                  done;
        logic                  int_dis;
        logic [IOB_WORD_W-1:0] buf_a_in;
        logic [IOB_WORD_W-1:0] buf_b_in;
        logic [IOB_WORD_W-1:0] buf_a_out;
        logic [IOB_WORD_W-1:0] buf_b_out;
        iob_dev_s              out;
    } iob_dst_s;

    iob_dst_s              st_reg;
    iob_dst_s              st_next;

    logic                  wr_en;
    logic [7:0]            wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic [7:0]            rd_addr;
    logic [31:0]           rd_data;
    logic                  rd_ok;
    logic                  wr_ok;

    logic                  is_inout;
    logic                  selected;
    logic [2:0]            xfr;
    logic [1:0]            fn;
    logic                  no_xfer;
    logic                  skip_hit;
    logic [IOB_WORD_W-1:0] a_mask;
    logic [IOB_WORD_W-1:0] b_mask;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign is_inout = cpu_in.strobe && (cpu_in.instr[IOB_OPC_HI:IOB_OPC_LO] == IOB_OPC_INOUT);
    assign selected = is_inout && (cpu_in.instr[IOB_DEV_HI:IOB_DEV_LO] == DEV_CODE)
                      && (DEV_CODE != DEV_UNUSED) && (DEV_CODE != DEV_CPU);
    assign xfr      = cpu_in.instr[IOB_XFR_HI:IOB_XFR_LO];
    assign fn       = cpu_in.instr[IOB_FN_HI:IOB_FN_LO];
    assign no_xfer  = (xfr == XFR_NONE0) || (xfr == XFR_SKIP);

    // narrow buffers supply only their low bits
    genvar gi;
    generate
        for (gi = 0; gi < IOB_WORD_W; gi++)
        begin : g_mask
            assign a_mask[gi] = HAS_A && (gi < A_WIDTH);
            assign b_mask[gi] = HAS_B && (gi < B_WIDTH);
        end
    endgenerate

    always_comb
    begin
        case (fn)
            SK_BUSY_SET: skip_hit = st_reg.busy;
            SK_BUSY_CLR: skip_hit = !st_reg.busy;
            SK_DONE_SET: skip_hit = st_reg.done;
            SK_DONE_CLR: skip_hit = !st_reg.done;
            default:     skip_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next              = st_reg;
        st_next.out.resp     = 1'b0;
        st_next.out.skip     = 1'b0;
        st_next.out.acc_load = 1'b0;
        st_next.out.pulse    = 1'b0;

        // peripheral side: finish one unit, only while busy
        if (wr_en && wr_addr == REG_CONTROL && wr_strb[0])
        begin
            if (wr_data[CTL_FINISH] && st_reg.busy)
            begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
            else if (wr_data[CTL_BUSY] && !st_reg.done)
                st_next.busy = 1'b1;
        end
        if (wr_en && wr_addr == REG_BUF_A_IN)
            st_next.buf_a_in = wr_data[IOB_WORD_W-1:0];
        if (wr_en && wr_addr == REG_BUF_B_IN)
            st_next.buf_b_in = wr_data[IOB_WORD_W-1:0];

        if (selected)
        begin
            st_next.out.resp = 1'b1;
            if (xfr == XFR_SKIP)
                st_next.out.skip = skip_hit;
            else
            begin
                // program side wins over a same-cycle finish: the program has
                // already seen the old state and acts on it
                case (fn)
                    FN_START:
                    begin
                        st_next.done = 1'b0;
                        st_next.busy = 1'b1;
                    end
                    FN_CLEAR:
                    begin
                        st_next.done = 1'b0;
                        st_next.busy = 1'b0;
                    end
                    FN_PULSE: st_next.out.pulse = 1'b1;
                    default:  ;
                endcase
                if (!no_xfer)
                begin
                    case (xfr)
                        XFR_IN_A:
                        begin
                            st_next.out.acc_load = 1'b1;
                            st_next.out.acc      = st_reg.buf_a_in & a_mask;
                        end
                        XFR_IN_B:
                        begin
                            st_next.out.acc_load = 1'b1;
                            st_next.out.acc      = st_reg.buf_b_in & b_mask;
                        end
                        XFR_IN_C:
                        begin
                            st_next.out.acc_load = 1'b1;
                            st_next.out.acc      = '0;
                        end
                        XFR_OUT_A:
                            if (HAS_A)
                                st_next.buf_a_out = cpu_in.acc & a_mask;
                        XFR_OUT_B:
                            if (HAS_B)
                                st_next.buf_b_out = cpu_in.acc & b_mask;
                        default: ; // out C: no buffer, function only
                    endcase
                end
            end
        end

        if (cpu_in.mask_out)
            st_next.int_dis = cpu_in.acc[IOB_WORD_W-1-MASK_BIT];

        if (cpu_in.iorst)
        begin
            st_next.busy    = 1'b0;
            st_next.done    = 1'b0;
            st_next.int_dis = 1'b0;
        end

        st_next.out.irq = st_next.done && !st_next.int_dis;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign dev_out = st_reg.out;

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb
    begin
        rd_ok = 1'b1;
        case (rd_addr)
            REG_STATUS:    rd_data = {28'h0000000, st_reg.out.irq, st_reg.int_dis,
                                      st_reg.done, st_reg.busy};
            REG_CONTROL:   rd_data = REG_ZERO;
            REG_BUF_A_IN:  rd_data = {16'h0000, st_reg.buf_a_in};
            REG_BUF_B_IN:  rd_data = {16'h0000, st_reg.buf_b_in};
            REG_BUF_A_OUT: rd_data = {16'h0000, st_reg.buf_a_out};
            REG_BUF_B_OUT: rd_data = {16'h0000, st_reg.buf_b_out};
            REG_DEV_CODE:  rd_data = {26'h0000000, DEV_CODE};
            default:
            begin
                rd_data = REG_ZERO;
                rd_ok   = 1'b0;
            end
        endcase
    end

    assign wr_ok = (wr_addr == REG_CONTROL) || (wr_addr == REG_BUF_A_IN) || (wr_addr == REG_BUF_B_IN);

    iob_axil u_axil (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok),
        .wr_ok         (wr_ok)
    );

endmodule

//--- rtl/iob_pkg.sv
/*
 * Package for the in-out bus device interface: instruction field
 * positions, opcode and transfer codes, control functions, register
 * offsets and the structs that group bus signals.
 * Assumes a 16-bit instruction word, bit 0 the most significant.
 */
package iob_pkg;

    // ------------------------------------------------------------
    // instruction fields (bit 0 is the msb, so index = 15 - bit)
    // ------------------------------------------------------------
    localparam int          IOB_WORD_W    = 16;
    localparam int          IOB_CODE_W    = 6;
    localparam int          IOB_OPC_HI    = 15;
    localparam int          IOB_OPC_LO    = 13;
    localparam int          IOB_ACC_HI    = 12;
    localparam int          IOB_ACC_LO    = 11;
    localparam int          IOB_XFR_HI    = 10;
    localparam int          IOB_XFR_LO    = 8;
    localparam int          IOB_FN_HI     = 7;
    localparam int          IOB_FN_LO     = 6;
    localparam int          IOB_DEV_HI    = 5;
    localparam int          IOB_DEV_LO    = 0;
    localparam logic [2:0]  IOB_OPC_INOUT = 3'h3;

    // transfer field: bits 5-7
    localparam logic [2:0]  XFR_NONE0     = 3'h0;
    localparam logic [2:0]  XFR_IN_A      = 3'h1;
    localparam logic [2:0]  XFR_OUT_A     = 3'h2;
    localparam logic [2:0]  XFR_IN_B      = 3'h3;
    localparam logic [2:0]  XFR_OUT_B     = 3'h4;
    localparam logic [2:0]  XFR_IN_C      = 3'h5;
    localparam logic [2:0]  XFR_OUT_C     = 3'h6;
    localparam logic [2:0]  XFR_SKIP      = 3'h7;

    // control function / skip condition: bits 8-9
    localparam logic [1:0]  FN_NONE       = 2'h0;
    localparam logic [1:0]  FN_START      = 2'h1;
    localparam logic [1:0]  FN_CLEAR      = 2'h2;
    localparam logic [1:0]  FN_PULSE      = 2'h3;
    localparam logic [1:0]  SK_BUSY_SET   = 2'h0;
    localparam logic [1:0]  SK_BUSY_CLR   = 2'h1;
    localparam logic [1:0]  SK_DONE_SET   = 2'h2;
    localparam logic [1:0]  SK_DONE_CLR   = 2'h3;

    localparam logic [5:0]  DEV_UNUSED    = 6'h00;
    localparam logic [5:0]  DEV_CPU       = 6'h3F;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_STATUS    = 8'h00;
    localparam logic [7:0]  REG_CONTROL   = 8'h04;
    localparam logic [7:0]  REG_BUF_A_IN  = 8'h08;
    localparam logic [7:0]  REG_BUF_B_IN  = 8'h0C;
    localparam logic [7:0]  REG_BUF_A_OUT = 8'h10;
    localparam logic [7:0]  REG_BUF_B_OUT = 8'h14;
    localparam logic [7:0]  REG_DEV_CODE  = 8'h18;
    localparam logic [31:0] REG_ZERO      = 32'h0000_0000;
    localparam int          CTL_FINISH    = 0;
    localparam int          CTL_BUSY      = 1;
    localparam int          ST_BUSY       = 0;
    localparam int          ST_DONE       = 1;
    localparam int          ST_INTDIS     = 2;
    localparam int          ST_IRQ        = 3;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  strobe;
        logic [IOB_WORD_W-1:0] instr;
        logic [IOB_WORD_W-1:0] acc;
        logic                  iorst;
        logic                  mask_out;
    } iob_cpu_s;

    typedef struct packed {
        logic                  resp;
        logic                  skip;
        logic                  acc_load;
        logic [IOB_WORD_W-1:0] acc;
        logic                  irq;
        logic                  pulse;
    } iob_dev_s;

    typedef enum logic [1:0] {
        AX_IDLE,
        AX_WRESP,
        AX_RRESP
    } iob_axi_e;

endpackage

//--- test/io_bus_device_interface_test.sv
/* self-checking bench for iob_device: processor side via iob_cpu_model,
   peripheral side as an AXI4-Lite master. assumes default widths. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module io_bus_device_interface_test
    import iob_pkg::*;
;
    localparam logic [5:0] DEV = 6'h0A;
    logic        clk_sys = 1'h0;
    logic        rst_n   = 1'h0;
    iob_cpu_s    cpu_in;
    iob_dev_s    dev_out, ans;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [15:0] seed = 16'h0036, va, vb;
    logic [15:0] bad [4];
    int          num_errors = 0, total_checks = 0;
    iob_cpu_model cpu_u (.clk_sys(clk_sys), .dev_out(dev_out), .cpu_in(cpu_in));
    iob_device #(.DEV_CODE(DEV)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_in(cpu_in), .dev_out(dev_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    initial forever #12.5 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    // accumulator field random: the device must ignore it
    function automatic logic [15:0] io(input logic [2:0] x, input logic [1:0] f, input logic [5:0] c);
        return {IOB_OPC_INOUT, seed[1:0], x, f, c};
    endfunction
    function automatic logic [31:0] st(input logic b, input logic dn, input logic i);
        return {28'h0, dn & !i, i, dn, b};
    endfunction
    function automatic logic sk(input logic [1:0] c, input logic b, input logic dn);
        return c[1] ? dn ^ c[0] : b ^ c[0];
    endfunction
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do begin @(posedge clk_sys); if (awready) awvalid <= 1'h0; if (wready) wvalid <= 1'h0; end
        while (!bvalid);
        bready <= 1'h0;
        resp = bresp;
        @(posedge clk_sys);
    endtask
    task automatic axr(input logic [7:0] a);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do begin @(posedge clk_sys); if (arready) arvalid <= 1'h0; end while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        resp = rresp;
        @(posedge clk_sys);
    endtask
    task automatic chk_st(input logic [31:0] e);
        axr(REG_STATUS);
        `CHK("status", e, d)
    endtask
    task automatic go(input logic [2:0] x, input logic [1:0] f, input logic [5:0] c, input logic [15:0] a);
        cpu_u.issue(io(x, f, c), a, ans);
    endtask
    task automatic skips(input logic b, input logic dn);
        for (int c = 0; c < 4; c++)
        begin
            go(XFR_SKIP, c[1:0], DEV, rnd());
            `CHK("skip", sk(c[1:0], b, dn), ans.skip)
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        close_out;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        chk_st(32'h0);
        axr(8'h1C);
        `CHK("unmapped", {RESP_SLVERR, 32'h0}, {resp, d})
        $display("test reset done");
        go(XFR_NONE0, FN_START, DEV, 16'h0);
        `CHK("resp", 1'h1, ans.resp)
        chk_st(st(1'h1, 1'h0, 1'h0));
        skips(1'h1, 1'h0);
        axw(REG_CONTROL, 32'h1);
        `CHK("bresp", RESP_OKAY, resp)
        chk_st(st(1'h0, 1'h1, 1'h0));
        `CHK("irq", 1'h1, dev_out.irq)
        skips(1'h0, 1'h1);
        axw(REG_CONTROL, 32'h2);
        chk_st(st(1'h0, 1'h1, 1'h0));
        cpu_u.side(1'h0, 16'h0800);
        chk_st(st(1'h0, 1'h1, 1'h1));
        `CHK("irq", 1'h0, dev_out.irq)
        cpu_u.side(1'h0, 16'hF7FF);
        chk_st(st(1'h0, 1'h1, 1'h0));
        $display("test flags done");
        repeat (8)
        begin
            va = rnd();
            vb = rnd();
            axw(REG_BUF_A_IN, {16'h0, va});
            axw(REG_BUF_B_IN, {16'h0, vb});
            go(XFR_IN_A, FN_NONE, DEV, rnd());
            `CHK("in_a", {1'h1, 8'h0, va[7:0]}, {ans.acc_load, ans.acc})
            go(XFR_IN_B, FN_NONE, DEV, rnd());
            `CHK("in_b", {1'h1, vb}, {ans.acc_load, ans.acc})
            go(XFR_OUT_A, FN_NONE, DEV, va);
            axr(REG_BUF_A_OUT);
            `CHK("out_a", {24'h0, va[7:0]}, d)
            go(XFR_OUT_B, FN_NONE, DEV, vb);
            axr(REG_BUF_B_OUT);
            `CHK("out_b", {16'h0, vb}, d)
            go(XFR_NONE0, FN_NONE, va[5:0], vb);
        end
        chk_st(st(1'h0, 1'h1, 1'h0));
        go(XFR_IN_A, FN_START, DEV, 16'h0);
        `CHK("in_start", {1'h1, 8'h0, va[7:0]}, {ans.acc_load, ans.acc})
        chk_st(st(1'h1, 1'h0, 1'h0));
        $display("test transfers done");
        bad = '{io(XFR_NONE0, FN_CLEAR, 6'h00), io(XFR_NONE0, FN_CLEAR, 6'h3F),
                io(XFR_NONE0, FN_CLEAR, 6'h0B), 16'h408A};
        foreach (bad[i])
        begin
            cpu_u.issue(bad[i], 16'h0, ans);
            `CHK("refused", 1'h0, ans.resp)
        end
        chk_st(st(1'h1, 1'h0, 1'h0));
        go(XFR_IN_C, FN_PULSE, DEV, 16'hFFFF);
        `CHK("in_c", 18'h30000, {ans.acc_load, ans.pulse, ans.acc})
        go(XFR_OUT_C, FN_CLEAR, DEV, rnd());
        chk_st(32'h0);
        go(XFR_NONE0, FN_START, DEV, 16'h0);
        cpu_u.side(1'h0, 16'h0800);
        cpu_u.side(1'h1, 16'h0);
        chk_st(32'h0);
        $display("test decode done");
        close_out;
    end
endmodule

//--- test/iob_cpu_model.sv
/* processor side of the in-out bus: one instruction per call, plus
   the bus clear and mask-out pulses. assumes clk_sys only. */
`timescale 1ns/1ps
module iob_cpu_model
    import iob_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire iob_dev_s dev_out,
    output iob_cpu_s      cpu_in
);
    initial cpu_in = '0;
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic issue(input logic [15:0] ins, input logic [15:0] a, output iob_dev_s r);
        cpu_in.instr  <= ins;
        cpu_in.acc    <= a;
        cpu_in.strobe <= 1'h1;
        @(posedge clk_sys);
        cpu_in.strobe <= 1'h0;
        // lines no longer qualified: garbage, not stale data
        cpu_in.instr  <= ~ins;
        cpu_in.acc    <= ~a;
        #1 r = dev_out;
        @(posedge clk_sys);
    endtask
    task automatic side(input logic clr, input logic [15:0] a);
        cpu_in.iorst    <= clr;
        cpu_in.mask_out <= !clr;
        cpu_in.acc      <= a;
        @(posedge clk_sys);
        cpu_in.iorst    <= 1'h0;
        cpu_in.mask_out <= 1'h0;
    endtask
endmodule

//--- test/iob_device_sva.sv
/* checker for iob_device: select decode, answer pulses, irq drop.
   sees only the device ports; attached by the bind at the foot. */
`timescale 1ns/1ps
module iob_device_sva
    import iob_pkg::*;
#(
    parameter logic [5:0] DEV_CODE = 6'h0A,
    parameter int         MASK_BIT = 4
)
(
    input wire logic     clk_sys,
    input wire logic     rst_n,
    input wire iob_cpu_s cpu_in,
    input wire iob_dev_s dev_out
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic       hit;
    logic [2:0] xf;
    // bus clear only resets the flags; a same-cycle instruction is still answered
    assign hit = cpu_in.strobe && cpu_in.instr[15:13] == IOB_OPC_INOUT
                 && cpu_in.instr[5:0] == DEV_CODE;
    assign xf  = cpu_in.instr[10:8];
    sequence s_hit;
        hit;
    endsequence
    sequence s_quiet;
        !dev_out.resp && !dev_out.skip && !dev_out.acc_load && !dev_out.pulse;
    endsequence
    select_answer_a: assert property (s_hit |=> dev_out.resp) else $error("no answer");
    foreign_quiet_a: assert property (!hit |=> s_quiet) else $error("stray answer");
    skip_only_a: assert property (s_hit ##0 xf != XFR_SKIP |=> !dev_out.skip) else $error("bad skip");
    load_input_a: assert property (s_hit ##0 (xf == XFR_IN_A || xf == XFR_IN_B || xf == XFR_IN_C)
        |=> dev_out.acc_load) else $error("no load");
    no_move_a: assert property (s_hit ##0 (xf == XFR_NONE0 || xf == XFR_SKIP)
        |=> !dev_out.acc_load) else $error("load on no-move");
    missing_zero_a: assert property (s_hit ##0 xf == XFR_IN_C |=> dev_out.acc == '0) else $error("acc kept");
    pulse_fn_a: assert property (s_hit ##0 xf != XFR_SKIP ##0 cpu_in.instr[7:6] == FN_PULSE
        |=> dev_out.pulse) else $error("no pulse");
    mask_drop_a: assert property (cpu_in.mask_out && cpu_in.acc[15-MASK_BIT]
        |-> ##2 !dev_out.irq) else $error("irq despite mask");
    clear_drop_a: assert property (cpu_in.iorst |-> ##2 !dev_out.irq) else $error("irq after clear");
endmodule

bind iob_device iob_device_sva #(.DEV_CODE(DEV_CODE), .MASK_BIT(MASK_BIT)) sva_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .cpu_in(cpu_in), .dev_out(dev_out));
